// ### mks_keypad_model.sv
// behavioural switch matrix keypad with pulled-up row lines
`timescale 1ns/10ps
module mks_keypad_model
    import mks_pkg::*;
(
    // column drives from the scanner
    input  wire logic [NUM_COLS-1:0]          col_drive,
    // closed switches, bit col*NUM_ROWS+row
    input  wire logic [NUM_COLS*NUM_ROWS-1:0] key_closed,
    // row senses back to the scanner
    output logic      [NUM_ROWS-1:0]          row_sense
);
    // a closed switch pulls its row low only while its column is low
    always_comb begin
        row_sense = 6'h3f;
        for (int c = 0; c < NUM_COLS; c++) begin
            for (int r = 0; r < NUM_ROWS; r++) begin
                if (key_closed[c*NUM_ROWS+r] && col_drive[c] == 1'b0) begin
                    row_sense[r] = 1'b0;
                end
            end
        end
    end
endmodule : mks_keypad_model

// ### mks_pkg.sv
// constants, register map and types of the matrix keypad scanner
// Overview of operation
// - five column drives, six pulled-up row senses
// - scanning off after reset until firmware enables it
// - timing uses a 1 kHz tick, running only with tick enable
// - idle scan: all columns low, waiting for a low row
// - low row rechecked after debounce; gone returns, held starts scan
// - debounce period 4 ms to 256 ms in 4 ms steps
// - debounce value times 4 ms, 0x3f is 252 ms, 0x00 is 256 ms
// - scan drives one column low, checks each row, then next column
// - row check interval 1 to 4 ms, independent of order
// - only a single closed key is reported
// - columns follow the order registers, rows a fixed order
// - with scanning on, results load only on a valid key
// - a valid key loads the results and sets the detection flag; the interrupt rises only with interrupt enable set
// - scanning continues without waiting for interrupt service
// - after detection wait release, debounce, restart if still pressed
// - after confirmed release drive all columns low and wait again
// - with scanning off, columns follow the column register
// - column bits 4..0 map to pins, zero drives the column low
// - row bits 5..0 reflect the row pins, zero means low
// - a dimension register limits the rows and columns considered
package mks_pkg;

    // keypad geometry
    localparam int NUM_COLS = 5;
    localparam int NUM_ROWS = 6;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_COL  = 8'hd1;
    localparam logic [7:0] IDX_ROW  = 8'hd2;
    localparam logic [7:0] IDX_SCAN = 8'hd3;
    localparam logic [7:0] IDX_STAT = 8'hd4;
    localparam logic [7:0] IDX_ORDL = 8'hd5;
    localparam logic [7:0] IDX_ORDH = 8'hd6;
    localparam logic [7:0] IDX_DIM  = 8'hd7;
    localparam logic [7:0] IDX_MCLK = 8'hd8;
    localparam int         ADDR_W   = 12;

    // reset values
    localparam logic [4:0]  RST_COL  = 5'h1f;
    localparam logic [5:0]  RST_ROW  = 6'h3f;
    localparam logic [7:0]  RST_SCAN = 8'h00;
    localparam logic [11:0] RST_ORDL = 12'h210;
    localparam logic [7:0]  RST_ORDH = 8'h43;
    localparam logic [7:0]  RST_DIM  = 8'h65;
    localparam logic [7:0]  RST_MCLK = 8'h00;

    // field positions
    localparam int STAT_IEN  = 0;
    localparam int STAT_DET  = 1;
    localparam int STAT_SCEN = 2;
    localparam int STAT_BUSY = 3;
    localparam int MCLK_KEN  = 6;
    localparam int SC_LSB    = 0;
    localparam int DB_LSB    = 2;
    localparam int DIM_C_LSB = 0;
    localparam int DIM_R_LSB = 4;

    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] DB_ZERO_UNITS = 7'd64;
    localparam logic [2:0] SC_ZERO_MS    = 3'd4;

    // scanner states
    typedef enum logic [2:0] {
        MKS_OFF,
        MKS_WAIT_PRESS,
        MKS_PRESS_DB,
        MKS_SCAN,
        MKS_WAIT_REL,
        MKS_REL_DB
    } mks_state_t;

endpackage : mks_pkg

// ### mks_scanner.sv
// keypad scanner with apb register slave
`timescale 1ns/10ps
module mks_scanner
    import mks_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC
) (
    // apb
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // keypad matrix
    output logic      [NUM_COLS-1:0] col_drive,
    input  wire logic [NUM_ROWS-1:0] row_sense,
    // keypad interrupt
    output logic                   key_irq
);

    localparam int TW = $clog2(TICK_DIV);

    // refuse a divider the tick counter cannot serve
    generate
        if (TICK_DIV < 2) begin : g_bad_div
            $error("mks_scanner: TICK_DIV must be at least 2");
        end
    endgenerate

    // bus interface flops
    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    // software registers
    logic [4:0]          col_reg_ff;
    logic [5:0]          row_lat_ff;
    logic [7:0]          scan_ff;
    logic                ien_ff;
    logic                det_ff;
    logic                scen_ff;
    logic [11:0]         ordl_ff;
    logic [7:0]          ordh_ff;
    logic [7:0]          dim_ff;
    logic [7:0]          mclk_ff;
    logic                irq_ff;
    // scanner state
    mks_state_t          state_ff;
    mks_state_t          nxt_state;
    logic [2:0]          slot_ff;
    logic [2:0]          nxt_slot;
    logic [2:0]          rowi_ff;
    logic [2:0]          nxt_rowi;
    logic [8:0]          tmr_ff;
    logic [8:0]          nxt_tmr;
    logic [1:0]          hits_ff;
    logic [1:0]          nxt_hits;
    logic [2:0]          hcol_ff;
    logic [2:0]          nxt_hcol;
    logic [2:0]          hrow_ff;
    logic [2:0]          nxt_hrow;
    logic                load_key;
    logic [4:0]          col_out_ff;
    logic [4:0]          nxt_col_out;
    logic [5:0]          rows_ff;
    logic [TW-1:0]       tick_cnt_ff;
    logic                tick_ff;

    // apb address decode
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
    wire       hit_col  = aligned && (idx == IDX_COL);
    wire       hit_row  = aligned && (idx == IDX_ROW);
    wire       hit_scan = aligned && (idx == IDX_SCAN);
    wire       hit_stat = aligned && (idx == IDX_STAT);
    wire       hit_ordl = aligned && (idx == IDX_ORDL);
    wire       hit_ordh = aligned && (idx == IDX_ORDH);
    wire       hit_dim  = aligned && (idx == IDX_DIM);
    wire       hit_mclk = aligned && (idx == IDX_MCLK);
    wire       mapped   = hit_col | hit_row | hit_scan | hit_stat |
                          hit_ordl | hit_ordh | hit_dim | hit_mclk;
    wire       setup    = psel & ~penable;
    wire       wr_go    = psel & penable & pwrite & pready_ff & ~pslverr_ff;

    // per-register write strobes
    wire wr_col  = wr_go & hit_col;
    wire wr_scan = wr_go & hit_scan;
    wire wr_stat = wr_go & hit_stat;
    wire wr_ordl = wr_go & hit_ordl;
    wire wr_ordh = wr_go & hit_ordh;
    wire wr_dim  = wr_go & hit_dim;
    wire wr_mclk = wr_go & hit_mclk;

    // row register: live pins in bypass, else latched key
    wire [5:0] row_view = scen_ff ? row_lat_ff : rows_ff;
    wire busy = (state_ff != MKS_OFF) && (state_ff != MKS_WAIT_PRESS);
    wire [7:0] stat_view = {4'h0, busy, scen_ff, det_ff, ien_ff};

    // read data selection
    wire [31:0] rd_data =
        hit_col  ? {27'h0, col_reg_ff} :
        hit_row  ? {26'h0, row_view}   :
        hit_scan ? {24'h0, scan_ff}    :
        hit_stat ? {24'h0, stat_view}  :
        hit_ordl ? {20'h0, ordl_ff}    :
        hit_ordh ? {24'h0, ordh_ff}    :
        hit_dim  ? {24'h0, dim_ff}     :
        hit_mclk ? {24'h0, mclk_ff}    : 32'h0;

    // apb answer: one access cycle after each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup) begin
                prdata_ff <= rd_data;
            end
        end
    end

    // configuration fields
    wire [1:0] row_check_interval  = scan_ff[SC_LSB +: 2];
    wire [5:0] debounce_period  = scan_ff[DB_LSB +: 6];
    wire [2:0] dim_c   = dim_ff[DIM_C_LSB +: 3];
    wire [2:0] dim_r   = dim_ff[DIM_R_LSB +: 3];
    wire       tick_en = mclk_ff[MCLK_KEN];

    // active size, zero or too large means full
    wire [2:0] ncols = ((dim_c == 3'd0) || (dim_c > 3'(NUM_COLS))) ?
                       3'(NUM_COLS) : dim_c;
    wire [2:0] nrows = ((dim_r == 3'd0) || (dim_r > 3'(NUM_ROWS))) ?
                       3'(NUM_ROWS) : dim_r;

    // debounce ticks: value times four, zero counts as 64 units
    wire [6:0] db_units = (debounce_period == 6'h00) ? DB_ZERO_UNITS
                                            : {1'b0, debounce_period};
    wire [8:0] db_ticks = {db_units, 2'b00};
    // row check interval in ms, zero selects four
    wire [2:0] sc_ticks = (row_check_interval == 2'd0) ? SC_ZERO_MS
                                           : {1'b0, row_check_interval};

    // rows outside the active size read as released
    logic [5:0] row_act;
    genvar gr;
    generate
        for (gr = 0; gr < NUM_ROWS; gr++) begin : g_row_act
            assign row_act[gr] = (3'(gr) < nrows);
        end
    endgenerate
    wire [5:0] rows_eff = rows_ff | ~row_act;
    wire       any_low  = ~&rows_eff;

    // column order slots, one nibble each
    wire [19:0] ord_all = {ordh_ff, ordl_ff};
    logic [2:0] slot_col [NUM_COLS];
    genvar gs;
    generate
        for (gs = 0; gs < NUM_COLS; gs++) begin : g_slot
            assign slot_col[gs] = ord_all[4*gs +: 3];
        end
    endgenerate
    wire [2:0] cur_col = slot_col[slot_ff];
    wire       slot_ok = (cur_col < ncols);

    // timer events
    wire db_done    = tick_ff && (tmr_ff == db_ticks - 9'd1);
    wire sc_done    = tick_ff && (tmr_ff == {6'h0, sc_ticks} - 9'd1);
    wire last_row   = (rowi_ff == nrows - 3'd1);
    wire last_slot  = (slot_ff == 3'(NUM_COLS - 1));
    wire row_hit    = ~rows_ff[rowi_ff];
    wire [4:0] col_one_low = ~(5'h01 << cur_col);

    // 1 kHz tick, held while its enable is clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else if (!tick_en) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else begin
            tick_ff <= (tick_cnt_ff == TW'(TICK_DIV - 1));
            if (tick_cnt_ff == TW'(TICK_DIV - 1)) begin
                tick_cnt_ff <= '0;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + TW'(1);
            end
        end
    end

    // scanner next-state logic
    always_comb begin
        nxt_state   = state_ff;
        nxt_slot    = slot_ff;
        nxt_rowi    = rowi_ff;
        nxt_tmr     = tick_ff ? tmr_ff + 9'd1 : tmr_ff;
        nxt_hits    = hits_ff;
        nxt_hcol    = hcol_ff;
        nxt_hrow    = hrow_ff;
        load_key    = 1'b0;
        nxt_col_out = 5'h00;
        if (!scen_ff) begin
            nxt_state   = MKS_OFF;
            nxt_col_out = col_reg_ff;
        end else begin
            unique case (state_ff)
                MKS_OFF: begin
                    nxt_state = MKS_WAIT_PRESS;
                    nxt_tmr   = 9'd0;
                end
                MKS_WAIT_PRESS: begin
                    nxt_tmr = 9'd0;
                    if (any_low) begin
                        nxt_state = MKS_PRESS_DB;
                    end
                end
                MKS_PRESS_DB: begin
                    if (db_done) begin
                        nxt_tmr = 9'd0;
                        nxt_slot = 3'd0;
                        nxt_rowi = 3'd0;
                        nxt_hits = 2'd0;
                        nxt_state = any_low ? MKS_SCAN
                                            : MKS_WAIT_PRESS;
                    end
                end
                MKS_SCAN: begin
                    nxt_col_out = slot_ok ? col_one_low : 5'h1f;
                    if (!slot_ok || sc_done) begin
                        nxt_tmr = 9'd0;
                        if (slot_ok && row_hit) begin
                            nxt_hits = (hits_ff == 2'd2) ? 2'd2
                                                         : hits_ff + 2'd1;
                            nxt_hcol = cur_col;
                            nxt_hrow = rowi_ff;
                        end
                        if (slot_ok && !last_row) begin
                            nxt_rowi = rowi_ff + 3'd1;
                        end else begin
                            nxt_rowi = 3'd0;
                            nxt_slot = slot_ff + 3'd1;
                            if (last_slot) begin
                                nxt_state   = MKS_WAIT_REL;
                                nxt_col_out = 5'h00;
                                load_key    = (nxt_hits == 2'd1);
                            end
                        end
                    end
                end
                MKS_WAIT_REL: begin
                    nxt_tmr = 9'd0;
                    if (!any_low) begin
                        nxt_state = MKS_REL_DB;
                    end
                end
                MKS_REL_DB: begin
                    if (db_done) begin
                        nxt_tmr = 9'd0;
                        if (!any_low) begin
                            nxt_state = MKS_WAIT_PRESS;
                        end
                    end
                end
            endcase
        end
    end

    // scanner state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= MKS_OFF;
            slot_ff    <= 3'd0;
            rowi_ff    <= 3'd0;
            tmr_ff     <= 9'd0;
            hits_ff    <= 2'd0;
            hcol_ff    <= 3'd0;
            hrow_ff    <= 3'd0;
            col_out_ff <= RST_COL;
            rows_ff    <= RST_ROW;
        end else begin
            state_ff   <= nxt_state;
            slot_ff    <= nxt_slot;
            rowi_ff    <= nxt_rowi;
            tmr_ff     <= nxt_tmr;
            hits_ff    <= nxt_hits;
            hcol_ff    <= nxt_hcol;
            hrow_ff    <= nxt_hrow;
            col_out_ff <= nxt_col_out;
            rows_ff    <= row_sense;     // rows carry pull-ups
        end
    end

    // result patterns for the identified key
    wire [4:0] key_col_pat = ~(5'h01 << nxt_hcol);
    wire [5:0] key_row_pat = ~(6'h01 << nxt_hrow);

    // column and row result registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_reg_ff <= RST_COL;
            row_lat_ff <= RST_ROW;
        end else if (load_key) begin
            col_reg_ff <= key_col_pat;
            row_lat_ff <= key_row_pat;
        end else if (wr_col) begin
            col_reg_ff <= pwdata[4:0];
        end
    end

    // detection flag: hardware set wins over a write-one clear
    wire det_clr = wr_stat & pwdata[STAT_DET];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            det_ff <= load_key | (det_ff & ~det_clr);
            irq_ff <= (load_key | (det_ff & ~det_clr)) & ien_ff;
        end
    end

    // control registers; scanning off at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_ff <= RST_SCAN;
            ien_ff  <= 1'b0;
            scen_ff <= 1'b0;
            ordl_ff <= RST_ORDL;
            ordh_ff <= RST_ORDH;
            dim_ff  <= RST_DIM;
            mclk_ff <= RST_MCLK;
        end else begin
            if (wr_scan) begin
                scan_ff <= pwdata[7:0];
            end
            if (wr_stat) begin
                ien_ff  <= pwdata[STAT_IEN];
                scen_ff <= pwdata[STAT_SCEN];
            end
            if (wr_ordl) begin
                ordl_ff <= pwdata[11:0];
            end
            if (wr_ordh) begin
                ordh_ff <= pwdata[7:0];
            end
            if (wr_dim) begin
                dim_ff <= pwdata[7:0];
            end
            if (wr_mclk) begin
                mclk_ff <= pwdata[7:0];
            end
        end
    end

    // outputs straight from flops
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign col_drive = col_out_ff;
    assign key_irq   = irq_ff;

endmodule : mks_scanner

// ### mks_scanner_checker.sv
// port-level assertions for the keypad scanner
`timescale 1ns/10ps
module mks_scanner_checker
    import mks_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC
) (
    // apb
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // keypad and interrupt
    input wire logic [NUM_COLS-1:0] col_drive,
    input wire logic [NUM_ROWS-1:0] row_sense,
    input wire logic                key_irq
);
    // address decode and completed writes
    wire [7:0] idx      = paddr[9:2];
    wire       mapped   = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0
                          && idx >= IDX_COL && idx <= IDX_MCLK;
    wire       setup    = psel && !penable;
    wire       wr_done  = psel && penable && pready && pwrite && !pslverr;
    wire       stat_wr  = wr_done && idx == IDX_STAT;
    wire       col_wr   = wr_done && idx == IDX_COL;
    wire       row_rd   = setup && !pwrite && mapped && idx == IDX_ROW;
    logic       scen_ff, scen_d1_ff, scen_d2_ff, stat_wr_ff;
    logic [4:0] col_wr_ff;
    // shadow of scan enable and last column write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scen_ff    <= 1'b0;
            scen_d1_ff <= 1'b0;
            scen_d2_ff <= 1'b0;
            stat_wr_ff <= 1'b0;
            col_wr_ff  <= 5'h1f;
        end else begin
            if (stat_wr) scen_ff <= pwdata[STAT_SCEN];
            if (col_wr) col_wr_ff <= pwdata[4:0];
            scen_d1_ff <= scen_ff;
            scen_d2_ff <= scen_d1_ff;
            stat_wr_ff <= stat_wr;
        end
    end
    wire off_steady = !scen_ff && !scen_d1_ff && !scen_d2_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_irq_pending;
        key_irq && !stat_wr && !stat_wr_ff;
    endsequence
    a_apb_answer: assert property (setup |=> s_access)
        else $error("no access answer");
    a_bad_addr: assert property (setup && !mapped |=> pslverr)
        else $error("bad address not refused");
    a_reset_idle: assert property ($rose(presetn) |->
        col_drive == 5'h1f && !key_irq) else $error("not idle after reset");
    a_cols_follow: assert property (col_wr && off_steady |->
        ##[1:3] col_drive == col_wr_ff) else $error("pins ignore columns");
    a_rows_live: assert property (row_rd && off_steady &&
        $stable(row_sense) && row_sense == $past(row_sense, 2)
        |=> prdata == {26'h0, $past(row_sense)})
        else $error("row register not live");
    a_one_col_low: assert property (scen_ff && scen_d2_ff |->
        col_drive == 5'h00 || col_drive == 5'h1f || $onehot(~col_drive))
        else $error("several scan columns low");
    a_irq_holds: assert property (s_irq_pending |=> key_irq)
        else $error("interrupt dropped");
    a_release_wait: assert property ($rose(key_irq) |->
        ##[0:2] col_drive == 5'h00) else $error("columns not low");
endmodule : mks_scanner_checker

// ### mks_scanner_tb_top.sv
// self-checking bench for the matrix keypad scanner
`timescale 1ns/10ps
module mks_scanner_tb_top;
    import mks_pkg::*;
    localparam int MS = 10; // clocks per tick
    logic                pclk        = 1'b0;
    logic                presetn     = 1'b0;
    logic                psel        = 1'b0;
    logic                penable     = 1'b0;
    logic                pwrite      = 1'b0;
    logic [ADDR_W-1:0]   paddr       = 12'h000;
    logic [31:0]         pwdata      = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                key_irq;
    logic [NUM_COLS-1:0] col_drive;
    logic [NUM_ROWS-1:0] row_sense;
    logic [29:0]         key_closed  = 30'h0;
    logic [31:0]         exp_q[$];
    logic                rd_err;
    logic [5:0]          db_tab[4]   = '{6'h01, 6'h3f, 6'h00, 6'h02};
    logic [31:0]         rst_tab[8]  = '{32'h1f, 32'h3f, 32'h00, 32'h00,
                                         32'h210, 32'h43, 32'h65, 32'h00};
    logic [2:0]          s[5];
    logic [4:0]          first;
    int                  failures    = 0;
    int                  check_count = 0;
    int                  seed        = 32'h8953ebf7;
    int                  c, r, t, ms, per, last_c;

    always #50 pclk = ~pclk;

    // design and keypad
    mks_scanner #(.TICK_DIV(MS)) mks_scanner_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .col_drive(col_drive), .row_sense(row_sense),
        .key_irq(key_irq));
    mks_keypad_model mks_keypad_model_i (.col_drive(col_drive),
        .key_closed(key_closed), .row_sense(row_sense));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic in_range(input string what, input int lo, input int hi,
                            input int v);
        check(what, 32'h1, {31'h0, v >= lo && v <= hi});
    endtask : in_range

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) check("pready", 32'h1, 32'h0);
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, idx, 32'h0);
    endtask : rd

    task automatic wait_col_move(input logic [4:0] from, input int lim);
        t = 0;
        while (col_drive === from && t < lim) begin
            @(posedge pclk);
            t++;
        end
    endtask : wait_col_move

    // reads against the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) check("unexpected read", 32'h0, prdata);
            else check("read data", exp_q.pop_front(), prdata);
        end
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only row, unmapped index
        for (int i = 0; i < 8; i++) rd(8'(IDX_COL + i), rst_tab[i]);
        wr(IDX_ROW, 32'h0);
        rd(IDX_ROW, 32'h3f);
        rd(8'hd0, 32'h0);
        check("slave error", 32'h1, {31'h0, rd_err});
        // manual scanning with scan enable clear
        for (int i = 0; i < 6; i++) begin
            c = $unsigned($random(seed)) % NUM_COLS;
            r = $unsigned($random(seed)) % NUM_ROWS;
            key_closed <= 30'h0;
            key_closed[c*NUM_ROWS+r] <= 1'b1;
            wr(IDX_COL, {27'h0, ~(5'h01 << c)});
            repeat (4) @(posedge pclk);
            check("column pins", {27'h0, ~(5'h01 << c)},
                  {27'h0, col_drive});
            rd(IDX_ROW, {26'h0, ~(6'h01 << r)});
            wr(IDX_COL, {27'h0, ~(5'h01 << ((c + 1) % NUM_COLS))});
            repeat (4) @(posedge pclk);
            rd(IDX_ROW, 32'h3f);
        end
        key_closed <= 30'h0;
        wr(IDX_COL, 32'h1f);
        // scan enabled but tick off: nothing may progress
        wr(IDX_SCAN, 32'h05);
        wr(IDX_STAT, 32'h05);
        key_closed[0] <= 1'b1;
        repeat (200) @(posedge pclk);
        check("columns idle low", 32'h0, {27'h0, col_drive});
        check("irq tick off", 32'h0, {31'h0, key_irq});
        key_closed <= 30'h0;
        wr(IDX_MCLK, 32'h40);
        repeat (100) @(posedge pclk);
        // hardware scans, every interval code, four rotated column orders
        for (int i = 0; i < 4; i++) begin
            ms = ((i == 0) ? 4 : i) * NUM_ROWS * MS;
            per = ((db_tab[i] == 6'h00) ? 64 : db_tab[i]) * 4 * MS;
            for (int k = 0; k < 5; k++) s[k] = 3'((k + i + 1) % 5);
            c = $unsigned($random(seed)) % NUM_COLS;
            r = $unsigned($random(seed)) % NUM_ROWS;
            wr(IDX_ORDL, {20'h0, 1'b0, s[2], 1'b0, s[1], 1'b0, s[0]});
            wr(IDX_ORDH, {24'h0, 1'b0, s[4], 1'b0, s[3]});
            wr(IDX_SCAN, {24'h0, db_tab[i], 2'(i)});
            key_closed[c*NUM_ROWS+r] <= 1'b1;
            wait_col_move(5'h00, 4000);
            in_range("debounce", per - MS, per + MS + 4, t);
            first = col_drive;
            check("first column", {27'h0, ~(5'h01 << s[0])},
                  {27'h0, first});
            wait_col_move(first, 1000);
            in_range("row checks", ms - MS, ms + 2, t);
            t = 0;
            while (key_irq !== 1'b1 && t < 3000) begin
                @(posedge pclk);
                t++;
            end
            check("irq raised", 32'h1, {31'h0, key_irq});
            rd(IDX_COL, {27'h0, ~(5'h01 << c)});
            rd(IDX_ROW, {26'h0, ~(6'h01 << r)});
            rd(IDX_STAT, 32'h0f);
            key_closed <= 30'h0;
            repeat (per + 2 * MS + 10) @(posedge pclk);
            rd(IDX_STAT, 32'h07);
            wr(IDX_STAT, 32'h07);
            repeat (3) @(posedge pclk);
            check("irq acknowledged", 32'h0, {31'h0, key_irq});
            rd(IDX_STAT, 32'h05);
            last_c = c;
        end
        // two keys together report nothing
        wr(IDX_SCAN, 32'h05);
        key_closed[0] <= 1'b1;
        key_closed[NUM_ROWS+1] <= 1'b1;
        repeat (600) @(posedge pclk);
        check("irq two keys", 32'h0, {31'h0, key_irq});
        rd(IDX_STAT, 32'h0d);
        rd(IDX_COL, {27'h0, ~(5'h01 << last_c)});
        key_closed <= 30'h0;
        repeat (100) @(posedge pclk);
        // stop in mid-scan: pins take the column register
        key_closed[2*NUM_ROWS+3] <= 1'b1;
        wait_col_move(5'h00, 200);
        wr(IDX_STAT, 32'h01);
        repeat (3) @(posedge pclk);
        check("stopped columns", {27'h0, ~(5'h01 << last_c)},
              {27'h0, col_drive});
        key_closed <= 30'h0;
        check("reads all seen", 32'h0, exp_q.size());
        conclude();
    end
endmodule : mks_scanner_tb_top

bind mks_scanner mks_scanner_checker #(.TICK_DIV(TICK_DIV))
    mks_scanner_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .col_drive(col_drive), .row_sense(row_sense), .key_irq(key_irq));
